// ===== rtl/io_chk_pkg.sv
// Purpose: Shared constants and types for the port access checker
// Assumes: AXI4-Lite register window with 32-bit data, 12-bit addresses
// Notes: Flag bit positions mirror the status word image used by
//        the pop and return operations
`default_nettype none
package io_chk_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_FLAGS = 12'h000;
  localparam logic [11:0] OFF_MODE = 12'h004;
  localparam logic [11:0] OFF_MAP_BASE = 12'h008;
  localparam logic [11:0] OFF_SEG_LIMIT = 12'h00c;
  localparam logic [11:0] OFF_PORT_ADDR = 12'h010;
  localparam logic [11:0] OFF_ACCUM = 12'h014;
  localparam logic [11:0] OFF_SRC_INDEX = 12'h018;
  localparam logic [11:0] OFF_DST_INDEX = 12'h01c;
  localparam logic [11:0] OFF_SRC_SEG = 12'h020;
  localparam logic [11:0] OFF_DST_SEG = 12'h024;
  localparam logic [11:0] OFF_COUNT = 12'h028;
  localparam logic [11:0] OFF_CMD = 12'h02c;
  localparam logic [11:0] OFF_STATUS = 12'h030;
  localparam logic [11:0] OFF_TSS_BASE = 12'h100;
  localparam logic [11:0] OFF_TSS_END = 12'h1fc;
  localparam int unsigned TSS_WORDS = 64;
  localparam logic [16:0] TSS_BYTES = 17'h00100;
  // Field positions
  localparam int unsigned FLG_IF = 9;
  localparam int unsigned FLG_DF = 10;
  localparam int unsigned FLG_IO_PRIV_LEVEL = 12;
  localparam int unsigned FLG_VM = 17;
  localparam int unsigned MODE_PM = 8;
  localparam int unsigned CMD_WIDTH = 4;
  localparam int unsigned CMD_LOOP = 6;
  localparam int unsigned CMD_IMM = 7;
  localparam int unsigned CMD_PORT = 8;
  localparam int unsigned STS_BUSY = 0;
  localparam int unsigned STS_FAULT = 1;
  localparam int unsigned STS_DONE = 2;
  // Reset values
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [15:0] MAP_BASE_RST = 16'h0000;
  localparam logic [15:0] SEG_LIMIT_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [23:0] CMD_RST = 24'h00_0000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Operation codes, in order from zero
  typedef enum logic [3:0] {
    OP_NONE, OP_READ_ONE, OP_READ_BLOCK, OP_WRITE_ONE, OP_WRITE_BLOCK,
    OP_CLI, OP_STI, OP_POP_FLAGS_OP, OP_RETURN_FROM_IRQ
  } io_op_e;
endpackage
`default_nettype wire

// ===== rtl/perm_bit_test.sv
// Purpose: Tests the bitmap bits covering every byte of one port access
// Assumes: map_pair holds two consecutive bitmap bytes, low byte first
// Notes: Pure combinational; a byte outside the map arrives as all ones
`timescale 1ns/1ps
`default_nettype none
module perm_bit_test (
  // Access shape
  input wire logic [2:0] bit_pos,
  input wire logic [2:0] nbytes,
  // Two fetched bitmap bytes
  input wire logic [15:0] map_pair,
  // Result
  output logic deny
);
  logic [3:0] hit;
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_byte
      // One bit per byte port, window may straddle two bytes
      assign hit[i] = (3'(i) < nbytes) &&
                      map_pair[4'(bit_pos) + 4'(i)];
    end
  endgenerate
  assign deny = |hit;
endmodule // perm_bit_test
`default_nettype wire

// ===== rtl/io_port_access_checker.sv
// Purpose: Port I/O execution with privilege and permission map checks
// Assumes: Single clock; port and memory peers answer with one-cycle acks
// Notes: Register writes other than status are ignored while busy
// Function
// - Single port operations drive only the port bus; block transfers also use the memory bus
// - Single transfers use accumulator lanes; port from immediate or port reg
// - Block transfers use port reg; memory via source or destination pair
// - Repeated block steps index up when direction clear, else down
// - Interrupt-flag operations in protected mode need privilege within level, else fault; port operations go to the bitmap
// - Only pop or return at privilege zero may change the I/O level
// - Pop changes interrupt flag only within I/O level, silently otherwise
// - Privileged enough in protected mode: allow without reading bitmap
// - Less privileged or virtual mode: consult the task bitmap first
// - Bitmap starts at the map base held in the task segment
// - Port N is bit N mod 8 of bitmap byte N div 8
// - Every covered bit tested; any set bit faults
// - Two consecutive bitmap bytes fetched for every checked access that has a map
// - Bitmap bytes past the segment limit count as all set
// - Map base at or over limit means no map; checked accesses fault
// - Level and bitmap come from the running task's own copies
// - Port space is 64K byte ports; wide accesses cover consecutive ports
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module io_port_access_checker (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port bus
  output logic io_req,
  output logic io_we,
  output logic [15:0] io_addr,
  output logic [1:0] io_size,
  output logic [31:0] io_wdata,
  input wire logic [31:0] io_rdata,
  input wire logic io_ack,
  // Memory bus for block transfers
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_seg,
  output logic [31:0] mem_off,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // Events
  output logic protection_fault,
  output logic busy
);
  import io_chk_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DECIDE, ST_BM0, ST_BM1, ST_CHECK, ST_MEM_RD, ST_IO_CYC,
    ST_MEM_WR, ST_STEP, ST_EXEC, ST_DONE, ST_FAULT
  } state_e;

  state_e state_ff, nxt_state;
  logic [31:0] flags_ff, mode_ff, accum_ff, src_index_ff, dst_index_ff;
  logic [31:0] count_ff, xfer_ff;
  logic [15:0] map_base_ff, seg_limit_ff, port_addr_ff, src_seg_ff;
  logic [15:0] dst_seg_ff;
  logic [23:0] cmd_ff;
  logic fault_ff, done_ff, bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [7:0] bm_lo_ff, bm_hi_ff;
  logic [31:0] tss_mem [TSS_WORDS];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // Bus slave handshakes
  logic wr_go, rd_go, sw_wr, cmd_go, wr_hit, rd_hit, tss_wr;
  logic [11:0] wa, ra;
  assign wa = {s_axi_awaddr[11:2], 2'b00};
  assign ra = {s_axi_araddr[11:2], 2'b00};
  // Both channels taken together; master holds each until then
  assign wr_go = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign rd_go = ce && s_axi_arvalid && !rvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign busy = (state_ff != ST_IDLE);
  assign sw_wr = wr_go && !busy;
  assign tss_wr = sw_wr && wa >= OFF_TSS_BASE && wa <= OFF_TSS_END;
  assign cmd_go = sw_wr && wa == OFF_CMD && s_axi_wstrb[0];
  assign wr_hit = (wa <= OFF_STATUS) ||
                  (wa >= OFF_TSS_BASE && wa <= OFF_TSS_END);
  assign rd_hit = (ra <= OFF_STATUS) ||
                  (ra >= OFF_TSS_BASE && ra <= OFF_TSS_END);

  // Decoded command and task context
  io_op_e op;
  logic [1:0] width, current_priv, io_priv_level;
  logic loop_prefix, use_imm, pm, vm, is_port, is_block, is_read, checked;
  logic [2:0] nbytes;
  logic [15:0] port_no;
  assign op = io_op_e'(cmd_ff[3:0]);
  assign width = cmd_ff[CMD_WIDTH +: 2];
  assign loop_prefix = cmd_ff[CMD_LOOP];
  assign use_imm = cmd_ff[CMD_IMM];
  assign current_priv = mode_ff[1:0];
  assign pm = mode_ff[MODE_PM];
  assign io_priv_level = flags_ff[FLG_IO_PRIV_LEVEL +: 2];
  assign vm = pm && flags_ff[FLG_VM];
  assign is_port = (op inside {OP_READ_ONE, OP_READ_BLOCK,
                               OP_WRITE_ONE, OP_WRITE_BLOCK});
  assign is_block = (op == OP_READ_BLOCK) || (op == OP_WRITE_BLOCK);
  assign is_read = (op == OP_READ_ONE) || (op == OP_READ_BLOCK);
  assign nbytes = (width == 2'd0) ? 3'd1 : (width == 2'd1) ? 3'd2 : 3'd4;
  // Block transfers always take the port register
  assign port_no = (!is_block && use_imm) ?
                   cmd_ff[CMD_PORT +: 16] : port_addr_ff;
  assign checked = pm && (vm || current_priv > io_priv_level);

  // Bitmap byte fetch from the task segment image
  logic [16:0] bm_addr;
  logic [31:0] bm_word;
  logic [7:0] bm_byte;
  logic deny, no_map;
  assign bm_addr = {1'b0, map_base_ff} + {4'h0, port_no[15:3]} +
                   {16'h0000, state_ff == ST_BM1};
  assign bm_word = tss_mem[bm_addr[7:2]];
  // Bytes past the limit read as all ones
  assign bm_byte = (bm_addr > {1'b0, seg_limit_ff} || bm_addr >= TSS_BYTES)
                   ? 8'hff : bm_word[{bm_addr[1:0], 3'b000} +: 8];
  assign no_map = map_base_ff >= seg_limit_ff;

  perm_bit_test u_test (
    .bit_pos(port_no[2:0]),
    .nbytes(nbytes),
    .map_pair({bm_hi_ff, bm_lo_ff}),
    .deny(deny)
  );

  // Next state
  state_e go_xfer;
  assign go_xfer = (op == OP_WRITE_BLOCK) ? ST_MEM_RD : ST_IO_CYC;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (cmd_go) nxt_state = ST_DECIDE;
      ST_DECIDE: begin
        if (op == OP_CLI || op == OP_STI)
          nxt_state = (pm && current_priv > io_priv_level) ? ST_FAULT : ST_EXEC;
        else if (op == OP_POP_FLAGS_OP || op == OP_RETURN_FROM_IRQ)
          nxt_state = ST_EXEC;
        else if (!is_port || (loop_prefix && is_block && count_ff == WORD_RST))
          nxt_state = ST_DONE;
        else if (!checked)
          nxt_state = go_xfer;
        else if (no_map)
          nxt_state = ST_FAULT;
        else
          nxt_state = ST_BM0;
      end
      ST_BM0: nxt_state = ST_BM1;
      ST_BM1: nxt_state = ST_CHECK;
      ST_CHECK: nxt_state = deny ? ST_FAULT : go_xfer;
      ST_MEM_RD: if (mem_ack) nxt_state = ST_IO_CYC;
      ST_IO_CYC: begin
        if (io_ack) begin
          if (op == OP_READ_BLOCK) nxt_state = ST_MEM_WR;
          else if (is_block) nxt_state = ST_STEP;
          else nxt_state = ST_DONE;
        end
      end
      ST_MEM_WR: if (mem_ack) nxt_state = ST_STEP;
      ST_STEP: begin
        // Each repeated item is checked again
        if (loop_prefix && count_ff != 32'h0000_0001) nxt_state = ST_DECIDE;
        else nxt_state = ST_DONE;
      end
      ST_EXEC: nxt_state = ST_DONE;
      ST_DONE: nxt_state = ST_IDLE;
      ST_FAULT: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) state_ff <= ST_IDLE;
    else if (ce) state_ff <= nxt_state;
  end

  // Both bytes held, so the test never sees the low byte twice
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bm_lo_ff <= 8'h00;
      bm_hi_ff <= 8'h00;
    end else if (ce) begin
      if (state_ff == ST_BM0) bm_lo_ff <= bm_byte;
      if (state_ff == ST_BM1) bm_hi_ff <= bm_byte;
    end
  end

  // Port and memory buses kept apart
  assign io_req = (state_ff == ST_IO_CYC);
  assign io_we = !is_read;
  assign io_addr = port_no;
  assign io_size = width;
  assign io_wdata = xfer_ff;
  assign mem_req = (state_ff == ST_MEM_RD) || (state_ff == ST_MEM_WR);
  assign mem_we = (state_ff == ST_MEM_WR);
  assign mem_seg = (op == OP_WRITE_BLOCK) ? src_seg_ff : dst_seg_ff;
  assign mem_off = (op == OP_WRITE_BLOCK) ? src_index_ff : dst_index_ff;
  assign mem_wdata = xfer_ff;
  assign protection_fault = (state_ff == ST_FAULT);

  // Outgoing or incoming item
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) xfer_ff <= WORD_RST;
    else if (ce) begin
      if (state_ff == ST_DECIDE) xfer_ff <= accum_ff;
      else if (state_ff == ST_MEM_RD && mem_ack) xfer_ff <= mem_rdata;
      else if (state_ff == ST_IO_CYC && io_ack && is_read)
        xfer_ff <= io_rdata;
    end
  end

  // Accumulator lanes by width
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) accum_ff <= WORD_RST;
    else if (ce) begin
      if (sw_wr && wa == OFF_ACCUM)
        accum_ff <= merge(accum_ff, s_axi_wdata, s_axi_wstrb);
      else if (state_ff == ST_IO_CYC && io_ack && op == OP_READ_ONE) begin
        case (width)
          2'd0: accum_ff[7:0] <= io_rdata[7:0];
          2'd1: accum_ff[15:0] <= io_rdata[15:0];
          default: accum_ff <= io_rdata;
        endcase
      end
    end
  end

  // Index stepping and repeat count
  logic [31:0] step;
  assign step = {29'h0, nbytes};
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      src_index_ff <= WORD_RST;
      dst_index_ff <= WORD_RST;
      count_ff <= WORD_RST;
    end else if (ce) begin
      if (sw_wr && wa == OFF_SRC_INDEX)
        src_index_ff <= merge(src_index_ff, s_axi_wdata, s_axi_wstrb);
      if (sw_wr && wa == OFF_DST_INDEX)
        dst_index_ff <= merge(dst_index_ff, s_axi_wdata, s_axi_wstrb);
      if (sw_wr && wa == OFF_COUNT)
        count_ff <= merge(count_ff, s_axi_wdata, s_axi_wstrb);
      if (state_ff == ST_STEP) begin
        if (op == OP_WRITE_BLOCK)
          src_index_ff <= flags_ff[FLG_DF] ? src_index_ff - step
                                           : src_index_ff + step;
        else
          dst_index_ff <= flags_ff[FLG_DF] ? dst_index_ff - step
                                           : dst_index_ff + step;
        if (loop_prefix) count_ff <= count_ff - 32'h0000_0001;
      end
    end
  end

  // Status word: pop and return change the level only at privilege zero
  logic [31:0] img;
  assign img = accum_ff;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) flags_ff <= FLAGS_RST;
    else if (ce) begin
      if (sw_wr && wa == OFF_FLAGS)
        flags_ff <= merge(flags_ff, s_axi_wdata, s_axi_wstrb);
      else if (state_ff == ST_EXEC) begin
        case (op)
          OP_CLI: flags_ff[FLG_IF] <= 1'b0;
          OP_STI: flags_ff[FLG_IF] <= 1'b1;
          OP_POP_FLAGS_OP, OP_RETURN_FROM_IRQ: begin
            flags_ff[FLG_DF] <= img[FLG_DF];
            if (current_priv == 2'd0)
              flags_ff[FLG_IO_PRIV_LEVEL +: 2] <= img[FLG_IO_PRIV_LEVEL +: 2];
            if (op == OP_RETURN_FROM_IRQ || current_priv <= io_priv_level)
              flags_ff[FLG_IF] <= img[FLG_IF];
          end
          default: flags_ff <= flags_ff;
        endcase
      end
    end
  end

  // Task context set by software
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= MODE_RST;
      map_base_ff <= MAP_BASE_RST;
      seg_limit_ff <= SEG_LIMIT_RST;
      port_addr_ff <= HALF_RST;
      src_seg_ff <= HALF_RST;
      dst_seg_ff <= HALF_RST;
      cmd_ff <= CMD_RST;
    end else if (ce && sw_wr) begin
      case (wa)
        OFF_MODE: mode_ff <= merge(mode_ff, s_axi_wdata, s_axi_wstrb);
        OFF_MAP_BASE: map_base_ff <= s_axi_wdata[15:0];
        OFF_SEG_LIMIT: seg_limit_ff <= s_axi_wdata[15:0];
        OFF_PORT_ADDR: port_addr_ff <= s_axi_wdata[15:0];
        OFF_SRC_SEG: src_seg_ff <= s_axi_wdata[15:0];
        OFF_DST_SEG: dst_seg_ff <= s_axi_wdata[15:0];
        OFF_CMD: if (cmd_go) cmd_ff <= s_axi_wdata[23:0];
        default: cmd_ff <= cmd_ff;
      endcase
    end
  end

  // Segment image; no reset, software loads it
  always_ff @(posedge clock) begin
    if (ce && tss_wr)
      tss_mem[wa[7:2]] <= merge(tss_mem[wa[7:2]], s_axi_wdata, s_axi_wstrb);
  end

  // Sticky outcome flags; a new event beats a write-one clear
  logic clr_fault, clr_done;
  assign clr_fault = wr_go && wa == OFF_STATUS && s_axi_wstrb[0] &&
                     s_axi_wdata[STS_FAULT];
  assign clr_done = wr_go && wa == OFF_STATUS && s_axi_wstrb[0] &&
                    s_axi_wdata[STS_DONE];
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fault_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce) begin
      fault_ff <= (state_ff == ST_FAULT) || (fault_ff && !clr_fault);
      done_ff <= (state_ff == ST_DONE) || (done_ff && !clr_done);
    end
  end

  // Write response
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Read data
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = WORD_RST;
    case (ra)
      OFF_FLAGS: rd_mux = flags_ff;
      OFF_MODE: rd_mux = mode_ff;
      OFF_MAP_BASE: rd_mux = {16'h0000, map_base_ff};
      OFF_SEG_LIMIT: rd_mux = {16'h0000, seg_limit_ff};
      OFF_PORT_ADDR: rd_mux = {16'h0000, port_addr_ff};
      OFF_ACCUM: rd_mux = accum_ff;
      OFF_SRC_INDEX: rd_mux = src_index_ff;
      OFF_DST_INDEX: rd_mux = dst_index_ff;
      OFF_SRC_SEG: rd_mux = {16'h0000, src_seg_ff};
      OFF_DST_SEG: rd_mux = {16'h0000, dst_seg_ff};
      OFF_COUNT: rd_mux = count_ff;
      OFF_CMD: rd_mux = {8'h00, cmd_ff};
      OFF_STATUS: rd_mux = {29'h0, done_ff, fault_ff, busy};
      default: if (rd_hit) rd_mux = tss_mem[ra[7:2]];
    endcase
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= WORD_RST;
      rresp_ff <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic sw_flags_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) sw_flags_q <= 1'b0;
    else sw_flags_q <= ce && sw_wr && wa == OFF_FLAGS;
  end

  property p_no_mem_on_io;
    io_req |-> !mem_req;
  endproperty
  a_no_mem_on_io: assert property (p_no_mem_on_io)
    else $error("port cycle overlaps memory cycle");
  property p_block_port;
    (io_req && is_block) |-> io_addr == port_addr_ff;
  endproperty
  a_block_port: assert property (p_block_port)
    else $error("block transfer not on port register");
  property p_step_up;
    (ce && state_ff == ST_STEP && op == OP_READ_BLOCK && !flags_ff[FLG_DF])
      |=> dst_index_ff == $past(dst_index_ff) + $past(step);
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("destination index did not step up");
  property p_cli_gate;
    (ce && state_ff == ST_DECIDE && (op == OP_CLI || op == OP_STI) && pm &&
     current_priv > io_priv_level) |=> protection_fault ##1 !busy;
  endproperty
  a_cli_gate: assert property (p_cli_gate)
    else $error("interrupt flag op not faulted");
  property p_io_priv_level_hold;
    ($changed(io_priv_level) && !sw_flags_q) |-> $past(current_priv) == 2'd0 &&
      $past(state_ff) == ST_EXEC;
  endproperty
  a_io_priv_level_hold: assert property (p_io_priv_level_hold)
    else $error("io level changed without privilege zero");
  property p_if_hold;
    (ce && state_ff == ST_EXEC && op == OP_POP_FLAGS_OP && current_priv > io_priv_level)
      |=> $stable(flags_ff[FLG_IF]) && !protection_fault;
  endproperty
  a_if_hold: assert property (p_if_hold)
    else $error("interrupt flag changed by unprivileged pop");
  property p_no_bitmap;
    (ce && state_ff == ST_DECIDE && is_port && !checked &&
     !(loop_prefix && is_block && count_ff == WORD_RST))
      |=> state_ff inside {ST_IO_CYC, ST_MEM_RD};
  endproperty
  a_no_bitmap: assert property (p_no_bitmap)
    else $error("privileged access went to bitmap");
  property p_two_bytes;
    (ce && state_ff == ST_DECIDE && is_port && checked && !no_map &&
     !(loop_prefix && is_block && count_ff == WORD_RST))
      |=> state_ff == ST_BM0 ##1 state_ff == ST_BM1;
  endproperty
  a_two_bytes: assert property (p_two_bytes)
    else $error("bitmap bytes not fetched in pair");
  property p_deny;
    (ce && state_ff == ST_CHECK && deny) |=> protection_fault && !io_req;
  endproperty
  a_deny: assert property (p_deny)
    else $error("set bitmap bit did not fault");
  property p_no_map;
    (ce && state_ff == ST_DECIDE && is_port && checked && no_map &&
     !(loop_prefix && is_block && count_ff == WORD_RST)) |=> protection_fault;
  endproperty
  a_no_map: assert property (p_no_map)
    else $error("absent bitmap did not fault");
  property p_io_after_check;
    $rose(io_req) |-> $past(state_ff) inside {ST_CHECK, ST_DECIDE,
                                              ST_MEM_RD};
  endproperty
  a_io_after_check: assert property (p_io_after_check)
    else $error("port cycle without completed check");

  c_fault: cover property (protection_fault);
  c_checked_io: cover property (state_ff == ST_CHECK && !deny ##1 io_req);
  c_block_step: cover property (state_ff == ST_STEP && loop_prefix);
  c_pop_flags_op: cover property (state_ff == ST_EXEC && op == OP_POP_FLAGS_OP);
endmodule // io_port_access_checker
`default_nettype wire

// ===== test/port_peer.sv
// Purpose: Port device and memory stand-in for the checker bench
// Assumes: Requests are levels held until a one-cycle ack
// Notes: Ack delay varies; memory read data changes every cycle, port read data stays zero
`timescale 1ns/1ps
`default_nettype none
module port_peer (
  // Clock
  input wire logic clock,
  // Requests
  input wire logic io_req,
  input wire logic mem_req,
  // Answers
  output logic io_ack,
  output logic mem_ack,
  output logic [31:0] io_rdata,
  output logic [31:0] mem_rdata
);
  logic [1:0] cnt_ff = 2'h0;
  initial {io_ack, mem_ack, io_rdata, mem_rdata} = '0;
  // No second ack while the request still shows the first
  always @(posedge clock) begin
    cnt_ff <= cnt_ff + 2'h1;
    io_ack <= io_req && !io_ack && cnt_ff[0];
    mem_ack <= mem_req && !mem_ack && cnt_ff[1];
    io_rdata <= ~io_rdata + 32'h1;
    mem_rdata <= mem_rdata + 32'h5;
  end
endmodule // port_peer
`default_nettype wire

// ===== test/testbench.sv
// Purpose: Self-checking bench for the port access checker
// Assumes: Peer acks port and memory cycles after a short wait
// Notes: Expected port cycles and faults queue up in issue order
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import io_chk_pkg::*;
  localparam logic [31:0] FLT = 32'h8_0000;
  logic clock = 1'b0, resetn = 1'b0, ce = 1'b1, io_q = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, io_rdata, mem_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, io_req, io_ack, mem_req, mem_ack, io_we;
  logic protection_fault, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, io_size;
  logic [15:0] io_addr;
  logic [31:0] exp_q[$];
  int mismatches = 0, checked = 0;
  always #20 clock = ~clock;
  io_port_access_checker i_dut (.clock, .resetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .io_req,
    .io_we, .io_addr, .io_size, .io_wdata(), .io_rdata, .io_ack,
    .mem_req, .mem_we(), .mem_seg(), .mem_off(), .mem_wdata(), .mem_rdata,
    .mem_ack, .protection_fault, .busy);
  port_peer i_peer (.clock, .io_req, .mem_req, .io_ack, .mem_ack,
    .io_rdata, .mem_rdata);
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] pop();
    if (exp_q.size() == 0) return 32'hx;
    return exp_q.pop_front();
  endfunction
  function automatic logic [31:0] mk(input logic [3:0] op,
    input logic [1:0] w, input logic [15:0] p);
    return {8'h0, p, 1'b1, 1'b0, w, op};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge clock iff s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge clock iff s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clock iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge clock iff s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic run(input logic [31:0] c, input logic [31:0] e, input int n);
    repeat (n) exp_q.push_back(e);
    wr(OFF_CMD, c);
    @(posedge clock iff !busy);
  endtask
  // A port cycle is noted at its first cycle only
  always @(posedge clock) begin
    io_q <= io_req;
    if (protection_fault === 1'b1) compare(FLT, pop());
    if (io_req === 1'b1 && !io_q)
      compare({13'h0, io_we, io_size, io_addr}, pop());
  end
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    conclude();
  end
  initial begin
    logic [15:0] rp;
    void'($urandom(44));
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    // Map at 10h, all-ones guard byte at 20h, port 29h denied
    for (int i = 'h110; i <= 'h120; i += 4)
      wr(12'(i), (i == 'h114) ? 32'h200 : (i == 'h120) ? 32'hff : 32'h0);
    wr(OFF_MAP_BASE, 32'h10);
    wr(OFF_SEG_LIMIT, 32'h20);
    wr(OFF_MODE, 32'h103);
    wr(OFF_PORT_ADDR, 32'h28);
    run(mk(3, 0, 16'h28), 32'h4_0028, 1);
    run(mk(3, 0, 16'h29), FLT, 1);
    run(mk(3, 2, 16'h26), FLT, 1);
    run(mk(3, 0, 16'h7f), 32'h4_007f, 1);
    run(mk(3, 1, 16'h7f), FLT, 1);
    run(mk(3, 0, 16'h200), FLT, 1);
    run(32'h1, 32'h28, 1);
    run(32'h5, FLT, 1);
    run(32'h6, FLT, 1);
    wr(OFF_ACCUM, 32'h3200);
    run(32'h7, 32'h0, 0);
    rd_reg(OFF_FLAGS);
    compare(rd, 32'h0);
    wr(OFF_FLAGS, 32'h2_3000);
    run(mk(3, 0, 16'h29), FLT, 1);
    wr(OFF_MAP_BASE, 32'h30);
    run(mk(3, 0, 16'h28), FLT, 1);
    wr(OFF_FLAGS, 32'h0);
    wr(OFF_MODE, 32'h100);
    run(mk(3, 0, 16'h29), 32'h4_0029, 1);
    rp = 16'($urandom());
    run(mk(3, 2, rp), {16'h6, rp}, 1);
    // Return at level zero may raise the io level
    run(32'h8, 32'h0, 0);
    rd_reg(OFF_FLAGS);
    compare(rd, 32'h3200);
    wr(OFF_SRC_INDEX, 32'h40);
    wr(OFF_PORT_ADDR, 32'h60);
    wr(OFF_COUNT, 32'h2);
    run(32'h54, 32'h5_0060, 2);
    rd_reg(OFF_SRC_INDEX);
    compare(rd, 32'h44);
    wr(OFF_FLAGS, 32'h400);
    wr(OFF_COUNT, 32'h2);
    run(32'h54, 32'h5_0060, 2);
    rd_reg(OFF_SRC_INDEX);
    compare(rd, 32'h40);
    wr(OFF_FLAGS, 32'h0);
    wr(OFF_DST_INDEX, 32'h80);
    wr(OFF_COUNT, 32'h1);
    run(32'h62, 32'h2_0060, 1);
    rd_reg(OFF_DST_INDEX);
    compare(rd, 32'h84);
    rd_reg(12'h040);
    compare(32'(resp), 32'(RESP_SLVERR));
    compare(32'(exp_q.size()), 32'h0);
    conclude();
  end
endmodule // testbench
`default_nettype wire
